// file: rtl/fsrs_pkg.sv
`default_nettype none
package fsrs_pkg;
  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_SOFT_INIT = 8'h25;
  localparam logic [7:0] IDX_CAND      = 8'h2f;
  localparam logic [7:0] IDX_LIVE_LO   = 8'hb0;
  localparam logic [7:0] IDX_LIVE_HI   = 8'hbf;
  localparam logic [7:0] IDX_LIVE_X0   = 8'hae;
  localparam logic [7:0] IDX_LIVE_X1   = 8'haf;
  localparam logic [7:0] IDX_SNAP_BASE = 8'hc0;
  localparam logic [7:0] IDX_CORE_ID   = 8'hfe;
  localparam logic [7:0] IDX_JUMP      = 8'hff;
  // ---------------------------------------------------------------------------
  // Fields, values and bus layout
  // ---------------------------------------------------------------------------
  localparam int         CAND_BIT      = 1;
  localparam logic [7:0] CAND_MASK     = 8'h02;
  localparam logic [7:0] FULL_MASK     = 8'hff;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // Arbitrary value, chosen only to be recognisable in a readback.
  localparam logic [7:0] CORE_ID       = 8'h5a;
  localparam int         ADR_W         = 12;
  localparam int         IDX_LSB       = 2;
  localparam int         LIVE_SLOTS    = 18;
  localparam logic [4:0] LIVE_SLOT_X0  = 5'h10;
  localparam logic [4:0] LIVE_SLOT_X1  = 5'h11;
  localparam logic [2:0] SNAP_LINE     = 3'h4;
  localparam logic [2:0] LINE_MAX      = 3'h7;
  // ---------------------------------------------------------------------------
  // Pin order in the synchroniser vector
  // ---------------------------------------------------------------------------
  localparam int         PIN_REF       = 0;
  localparam int         PIN_LINK_RST  = 1;
  localparam int         PIN_ACTIVE    = 2;
  localparam int         PIN_LINE      = 3;
  localparam int         PIN_PIXEL     = 4;
  localparam int         PIN_COUNT     = 5;
endpackage
`default_nettype wire

// file: rtl/fsrs_stage_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fsrs_stage_if #(
  parameter int N = 64
);
  logic                       wr_en;
  logic [$clog2(N)-1:0]       wr_idx;
  logic [7:0]                 wr_data;
  logic [7:0]                 wr_direct_mask;
  logic                       commit;
  logic [$clog2(N)-1:0]       rd_idx;
  logic [7:0]                 rd_data;
  logic [N*8-1:0]             active;

  modport ctrl  (output wr_en, wr_idx, wr_data, wr_direct_mask, commit, rd_idx,
                 input rd_data, active);
  modport stage (input wr_en, wr_idx, wr_data, wr_direct_mask, commit, rd_idx,
                 output rd_data, active);
endinterface
`default_nettype wire

// file: rtl/fsrs_dbuf.sv
`timescale 1ns/10ps
`default_nettype none
module fsrs_dbuf #(
  parameter int N = 64
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Stage port
  fsrs_stage_if.stage stg
);
  import fsrs_pkg::*;

  typedef struct packed {
    logic [N*8-1:0] shadow;
    logic [N*8-1:0] active;
    logic [7:0]     rd;
  } fsrs_dbuf_type;

  fsrs_dbuf_type state;
  fsrs_dbuf_type next_state;

  // ---------------------------------------------------------------------------
  // Shadow and active stages
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (stg.wr_en) begin
      next_state.shadow[stg.wr_idx*8 +: 8] = stg.wr_data; // [R1] [R8]
      next_state.active[stg.wr_idx*8 +: 8] =
        (state.active[stg.wr_idx*8 +: 8] & ~stg.wr_direct_mask) |
        (stg.wr_data & stg.wr_direct_mask); // [R5] [R6]
    end
    // The copy takes the shadow after this cycle's write, so a write that
    // lands on the strobe still goes out with the field.
    if (stg.commit) begin
      next_state.active = next_state.shadow; // [R1] [R8]
    end
    next_state.rd = next_state.active[stg.rd_idx*8 +: 8];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign stg.rd_data = state.rd;
  assign stg.active  = state.active;
endmodule
`default_nettype wire

// file: rtl/fsrs_top.sv
// Summary of operation
// [R1] Written values wait in a shadow stage and reach the active stage at field commit.
// [R2] Field commit fires on the first reference sync rise after a link reset pulse.
// [R3] Status values are captured into a readback stage at the snapshot strobe.
// [R4] Snapshot fires at half the active pixels of the fourth blanking line.
// [R5] Writes to the soft initialisation register act at once, unbuffered.
// [R6] The candidate set bit takes effect at once on write.
// [R7] Pan-zoom vectors, identifier and jump status read live, unbuffered.
// [R8] Several writes before one commit leave only the last one committed.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module fsrs_top #(
  parameter int N_WR          = 64,
  parameter int N_RD          = 16,
  parameter int ACTIVE_PIXELS = 720,
  parameter int PIX_W         = 12
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  // Wishbone slave
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [fsrs_pkg::ADR_W-1:0]         wb_adr_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic [31:0]                        wb_dat_i,
  output logic      [31:0]                        wb_dat_o,
  output logic                                    wb_ack_o,
  // Video timing pins
  input  wire logic                               ref_sync,
  input  wire logic                               serial_link_reset,
  input  wire logic                               active_region_flag,
  input  wire logic                               line_sync,
  input  wire logic                               pixel_enable,
  // Processing side
  input  wire logic [N_RD*8-1:0]                  status_in,
  input  wire logic [fsrs_pkg::LIVE_SLOTS*8-1:0]  live_in,
  input  wire logic                               jump_status_first,
  input  wire logic                               jump_status_second,
  output logic      [N_WR*8-1:0]                  active_regs,
  output logic                                    soft_init_pulse,
  output logic                                    field_commit,
  output logic                                    readback_snapshot
);
  import fsrs_pkg::*;

  localparam int IDX_W = $clog2(N_WR);
  localparam int RD_W  = $clog2(N_RD);
  localparam logic [PIX_W-1:0] HALF_PIX = PIX_W'(ACTIVE_PIXELS / 2);

  typedef struct packed {
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] prev;
    logic                 armed;
    logic                 commit;
    logic [2:0]           blank_line;
    logic [PIX_W-1:0]     pix;
    logic                 snap_done;
    logic                 snap_pulse;
    logic [N_RD*8-1:0]    snap;
    logic                 phase;
    logic                 ack;
    logic [7:0]           dat;
    logic                 soft_init;
  } fsrs_top_type;

  fsrs_top_type state;
  fsrs_top_type next_state;

  fsrs_stage_if #(.N(N_WR)) stg ();

  fsrs_dbuf #(
    .N (N_WR)
  ) u_dbuf (
    .clk   (clk),
    .rst_n (rst_n),
    .stg   (stg)
  );

  // ---------------------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------------------
  function automatic logic fsrs_is_wr(input logic [7:0] idx);
    return {24'h0, idx} < N_WR;
  endfunction

  function automatic logic fsrs_is_snap(input logic [7:0] idx);
    return idx >= IDX_SNAP_BASE && {24'h0, idx} < N_RD + int'(IDX_SNAP_BASE);
  endfunction

  logic [7:0]           idx;
  logic                 mapped;
  logic                 req;
  logic                 wr;
  logic [PIN_COUNT-1:0] rise;
  logic                 fall_active;
  logic [7:0]           rd_value;
  logic [4:0]           live_slot;
  logic [7:0]           snap_off;

  assign idx    = wb_adr_i[IDX_LSB +: 8];
  assign mapped = wb_adr_i[ADR_W-1:IDX_LSB+8] == '0;
  assign req    = wb_cyc_i & wb_stb_i;
  // The write lands on the edge where the master sees ack.
  assign wr     = state.ack & req & wb_we_i & wb_sel_i[0] & mapped & fsrs_is_wr(idx);

  assign rise        = state.sync2 & ~state.prev;
  assign fall_active = ~state.sync2[PIN_ACTIVE] & state.prev[PIN_ACTIVE];
  assign snap_off    = idx - IDX_SNAP_BASE;

  // ---------------------------------------------------------------------------
  // Stage control
  // ---------------------------------------------------------------------------
  always_comb begin
    stg.wr_en          = wr;
    stg.wr_idx         = idx[IDX_W-1:0];
    stg.wr_data        = wb_dat_i[7:0];
    stg.rd_idx         = idx[IDX_W-1:0];
    stg.commit         = state.commit; // [R1]
    stg.wr_direct_mask = '0;
    if (idx == IDX_SOFT_INIT) begin
      stg.wr_direct_mask = FULL_MASK; // [R5]
    end else if (idx == IDX_CAND) begin
      stg.wr_direct_mask = CAND_MASK; // [R6]
    end
  end

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_value  = '0;
    live_slot = '0;
    if (idx >= IDX_LIVE_LO && idx <= IDX_LIVE_HI) begin
      live_slot = 5'(idx - IDX_LIVE_LO);
    end else if (idx == IDX_LIVE_X0) begin
      live_slot = LIVE_SLOT_X0;
    end else if (idx == IDX_LIVE_X1) begin
      live_slot = LIVE_SLOT_X1;
    end
    if (!mapped || idx == IDX_SOFT_INIT) begin
      rd_value = '0;
    end else if (fsrs_is_wr(idx)) begin
      rd_value = stg.rd_data;
    end else if ((idx >= IDX_LIVE_LO && idx <= IDX_LIVE_HI) ||
                 idx == IDX_LIVE_X0 || idx == IDX_LIVE_X1) begin
      rd_value = live_in[live_slot*8 +: 8]; // [R7]
    end else if (idx == IDX_CORE_ID) begin
      rd_value = CORE_ID; // [R7]
    end else if (idx == IDX_JUMP) begin
      rd_value = {6'h00, jump_status_second, jump_status_first}; // [R7]
    end else if (fsrs_is_snap(idx)) begin
      rd_value = state.snap[snap_off[RD_W-1:0]*8 +: 8]; // [R3]
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Pins come from the video source, so each passes two flip-flops.
    next_state.sync1 = {pixel_enable, line_sync, active_region_flag,
                        serial_link_reset, ref_sync};
    next_state.sync2 = state.sync1;
    next_state.prev  = state.sync2;

    // A link reset arms; the next reference rise fires one commit.
    next_state.commit = state.armed & rise[PIN_REF]; // [R2]
    next_state.armed  = rise[PIN_LINK_RST] | (state.armed & ~rise[PIN_REF]); // [R2]

    next_state.snap_pulse = 1'b0;
    if (!state.sync2[PIN_ACTIVE] && state.prev[PIN_ACTIVE] == 1'b0 &&
        state.blank_line == '0) begin
      next_state.blank_line = '0;
    end
    if (fall_active) begin
      next_state.blank_line = 3'h1; // [R4]
      next_state.pix        = '0;
      next_state.snap_done  = 1'b0;
    end else if (state.sync2[PIN_ACTIVE]) begin
      next_state.blank_line = '0;
    end else begin
      if (rise[PIN_LINE] && state.blank_line != '0 && state.blank_line != LINE_MAX) begin
        next_state.blank_line = state.blank_line + 3'h1; // [R4]
        next_state.pix        = '0;
      end
      if (state.sync2[PIN_PIXEL] && next_state.blank_line == SNAP_LINE &&
          !state.snap_done) begin
        next_state.pix = next_state.pix + PIX_W'(1);
        if (next_state.pix == HALF_PIX) begin
          next_state.snap_pulse = 1'b1; // [R4]
          next_state.snap_done  = 1'b1;
          next_state.snap       = status_in; // [R3]
        end
      end
    end

    // Two-cycle answer: the stage read settles, then data and ack register.
    next_state.phase = req & ~state.phase & ~state.ack;
    next_state.ack   = state.phase;
    if (state.phase) begin
      next_state.dat = rd_value;
    end
    next_state.soft_init = wr & (idx == IDX_SOFT_INIT); // [R5]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign wb_dat_o          = {24'h000000, state.dat};
  assign wb_ack_o          = state.ack;
  assign active_regs       = stg.active;
  assign soft_init_pulse   = state.soft_init;
  assign field_commit      = state.commit;
  assign readback_snapshot = state.snap_pulse;
endmodule
`default_nettype wire

// file: test/fsrs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fsrs_checker #(
  parameter int N_WR = 64
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // Bus
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [fsrs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  // Pins and stages
  input wire logic                       ref_sync,
  input wire logic                       active_region_flag,
  input wire logic                       jump_status_first,
  input wire logic                       jump_status_second,
  input wire logic [N_WR*8-1:0]          active_regs,
  input wire logic                       soft_init_pulse,
  input wire logic                       field_commit,
  input wire logic                       readback_snapshot
);
  import fsrs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------------------
  // Bus and strobe timing
  // ---------------------------------------------------------------------------
  a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |=> !wb_ack_o ##1 wb_ack_o)
    else $error("ack not two cycles after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_live_ident: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == {2'b00, IDX_CORE_ID, 2'b00}
    |-> wb_dat_o == {24'h0, CORE_ID})
    else $error("identifier readback wrong");
  a_live_jump: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == {2'b00, IDX_JUMP, 2'b00}
    |-> wb_dat_o[1:0] == $past({jump_status_second, jump_status_first}))
    else $error("jump status not live");
  a_init_now: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == {2'b00, IDX_SOFT_INIT, 2'b00}
    |=> soft_init_pulse)
    else $error("soft init write did not act at once");
  a_init_cause: assert property (
    soft_init_pulse
    |-> $past(wb_ack_o && wb_we_i && wb_adr_i == {2'b00, IDX_SOFT_INIT, 2'b00}))
    else $error("soft init pulse without write");
  // Only a commit or an acknowledged bus write may move the active stage.
  a_active_hold: assert property (
    !$past(field_commit) && !$past(wb_ack_o && wb_we_i) |-> $stable(active_regs))
    else $error("active stage changed without cause");
  a_commit_pulse: assert property (field_commit |=> !field_commit)
    else $error("commit strobe too long");
  a_commit_ref: assert property (field_commit |-> $past(ref_sync, 3))
    else $error("commit without reference sync");
  a_snap_blank: assert property (
    readback_snapshot |-> !active_region_flag && !$past(active_region_flag, 4))
    else $error("snapshot outside blanking");
  a_snap_pulse: assert property (readback_snapshot |=> !readback_snapshot)
    else $error("snapshot strobe too long");
endmodule
bind fsrs_top fsrs_checker #(.N_WR(N_WR)) u_fsrs_checker (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .ref_sync, .active_region_flag,
  .jump_status_first, .jump_status_second, .active_regs, .soft_init_pulse, .field_commit,
  .readback_snapshot);
`default_nettype wire

// file: test/test_field_synced_register_shadowing.sv
`timescale 1ns/10ps
`default_nettype none
module test_field_synced_register_shadowing;
  import fsrs_pkg::*;
  // Small pixel count keeps the blanking scenario short.
  localparam int AP = 8;
  logic                    clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0]        adr = '0;
  logic [3:0]              sel = 4'h0;
  logic [31:0]             dat = '0, dat_o;
  logic [4:0]              vid = '0;
  logic [127:0]            status_in = '0, snap_exp;
  logic [LIVE_SLOTS*8-1:0] live_in = '0;
  logic [1:0]              jump = '0;
  logic [511:0]            active;
  logic                    ack, init_p, commit, snap;
  logic [7:0]              r1;
  logic [31:0]             expq[$];
  int                      miscompares = 0, n_compared = 0, seed = 23;
  int                      n_init = 0, n_commit = 0, n_snap = 0;
  fsrs_top #(.ACTIVE_PIXELS(AP)) DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ref_sync(vid[PIN_REF]),
    .serial_link_reset(vid[PIN_LINK_RST]), .active_region_flag(vid[PIN_ACTIVE]),
    .line_sync(vid[PIN_LINE]), .pixel_enable(vid[PIN_PIXEL]), .status_in(status_in),
    .live_in(live_in), .jump_status_first(jump[0]), .jump_status_second(jump[1]),
    .active_regs(active), .soft_init_pulse(init_p), .field_commit(commit),
    .readback_snapshot(snap));
  always #25 clk = ~clk;
  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [ADR_W-1:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  // The request is held until ack is sampled, then dropped for one cycle.
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADR_W-1:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    wb(1'b0, a, 8'h00, 4'h1);
  endtask
  task automatic pin(input int p, input logic v, input int n);
    vid[p] <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic arm_and_ref(input logic arm);
    if (arm) begin
      pin(PIN_LINK_RST, 1'b1, 4);
      pin(PIN_LINK_RST, 1'b0, 4);
    end
    pin(PIN_REF, 1'b1, 8);
    pin(PIN_REF, 1'b0, 4);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      check(dat_o, expq.pop_front());
    end
    if (init_p === 1'b1) n_init++;
    if (commit === 1'b1) n_commit++;
    if (snap === 1'b1) n_snap++;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test;
  end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    r1 = 8'($random(seed));
    rd(12'hc0c, 8'h00);
    rd(ad(IDX_SOFT_INIT), 8'h00);
    wb(1'b1, ad(8'h03), r1, 4'h1);
    wb(1'b1, ad(8'h03), r1 ^ 8'ha5, 4'h1);
    wb(1'b1, ad(8'h04), r1, 4'h0);
    rd(ad(8'h03), 8'h00);
    arm_and_ref(1'b0);
    check(32'(n_commit), 32'h0);
    arm_and_ref(1'b1);
    check(32'(n_commit), 32'h1);
    check({24'h0, active[8*3 +: 8]}, {24'h0, r1 ^ 8'ha5});
    rd(ad(8'h03), r1 ^ 8'ha5);
    rd(ad(8'h04), 8'h00);
    wb(1'b1, ad(8'h03), r1, 4'h1);
    arm_and_ref(1'b0);
    rd(ad(8'h03), r1 ^ 8'ha5);
    wb(1'b1, ad(IDX_CAND), FULL_MASK, 4'h1);
    rd(ad(IDX_CAND), CAND_MASK);
    arm_and_ref(1'b1);
    rd(ad(IDX_CAND), FULL_MASK);
    wb(1'b1, ad(IDX_CAND), 8'h00, 4'h1);
    rd(ad(IDX_CAND), FULL_MASK & ~CAND_MASK);
    wb(1'b1, ad(IDX_SOFT_INIT), r1, 4'h1);
    @(posedge clk);
    check(32'(n_init), 32'h1);
    check({24'h0, active[int'(IDX_SOFT_INIT)*8 +: 8]}, {24'h0, r1});
    for (int i = 0; i < LIVE_SLOTS; i++) begin
      live_in[i*8 +: 8] <= 8'($random(seed));
      jump <= 2'($random(seed));
      @(posedge clk);
      rd(ad(i < 16 ? 8'(IDX_LIVE_LO + i) : 8'(IDX_LIVE_X0 + i - 16)),
         live_in[i*8 +: 8]);
    end
    rd(ad(IDX_CORE_ID), CORE_ID);
    rd(ad(IDX_JUMP), {6'h0, jump});
    status_in <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    pin(PIN_ACTIVE, 1'b1, 8);
    pin(PIN_ACTIVE, 1'b0, 8);
    repeat (2) begin
      pin(PIN_LINE, 1'b1, 3);
      pin(PIN_LINE, 1'b0, 5);
    end
    pin(PIN_PIXEL, 1'b1, AP);
    pin(PIN_PIXEL, 1'b0, 6);
    check(32'(n_snap), 32'h0);
    pin(PIN_LINE, 1'b1, 3);
    pin(PIN_LINE, 1'b0, 5);
    pin(PIN_PIXEL, 1'b1, AP / 2 - 1);
    pin(PIN_PIXEL, 1'b0, 6);
    check(32'(n_snap), 32'h0);
    pin(PIN_PIXEL, 1'b1, 1);
    pin(PIN_PIXEL, 1'b0, 6);
    check(32'(n_snap), 32'h1);
    // Status moves on after the strobe; reads must still show the captured values.
    snap_exp = status_in;
    status_in <= ~status_in;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      rd(ad(8'(IDX_SNAP_BASE + i)), snap_exp[i*8 +: 8]);
    end
    stop_test;
  end
endmodule
`default_nettype wire
